/* hw/sfl_feedback.sv */
// Feedback port logic: encoder counting, travel stops, origin search, Hall commutation and power fault.
//
// Behaviour
// [R1] The power fault output reflects only power-stage faults and never controller faults.
// [R2] Each encoder signal is tracked without lost counts up to 2.5 MHz.
// [R3] Quadrature edges as close as 100 ns apart are each resolved.
// [R4] Both quadrature channels and the index arrive as differential pairs and are received differentially.
// [R5] An active clockwise stop blocks clockwise motion and an active counter-clockwise stop blocks the other way.
// [R6] An origin command moves toward the home stop, reverses on it, and stops at the chosen event after release.
// [R7] The stop inputs have selectable polarity, high active for closed switches and low for open ones.
// [R8] The three Hall inputs form a six-step pattern that selects the commutation step.
// [R9] By default a Hall input is low while its phase is positive in clockwise rotation.
// [R10] A Hall phase setting, zero by default, shifts how Hall states map onto motor phases.
// [R11] Hall inputs drive commutation only for a brushless motor and are ignored for a brush motor.
// [R12] The motor type jumper selects brushless in position 1-2 and brush in position 2-3.
// [R13] The quadrature channels drive a signed position count and the index is captured as an event.
// [R14] Every stop, Hall and encoder input is synchronised to the clock before use.
`timescale 1ns/1ps
module sfl_feedback (
   // Clock and reset.
   input  logic                       clk,
   input  logic                       rstn,
   // Differential encoder pins.
   input  logic                       quad_a_pos,
   input  logic                       quad_a_neg,
   input  logic                       quad_b_pos,
   input  logic                       quad_b_neg,
   input  logic                       index_pulse_pos,
   input  logic                       index_pulse_neg,
   // Stop switch pins and their polarity.
   input  logic                       cw_travel_stop,
   input  logic                       ccw_travel_stop,
   input  logic                       home_stop,
   input  logic                       limit_active_high,
   // Hall sensor pins, phase setting and motor type strap.
   input  logic                       hall_a,
   input  logic                       hall_b,
   input  logic                       hall_c,
   input  logic [2:0]                 hall_phase_setting,
   input  logic                       motor_type_jumper,
   // Motion requests and origin search settings.
   input  logic                       motion_request_cw,
   input  logic                       motion_request_ccw,
   input  logic                       seek_origin_command,
   input  logic                       home_dir_ccw,
   input  logic                       home_stop_on_index,
   // Power stage fault sources.
   input  logic [sfl_pkg::PFAULT_W-1:0] power_stage_faults,
   // Encoder results.
   output logic [sfl_pkg::POS_W-1:0]  position_count,
   output logic [sfl_pkg::POS_W-1:0]  index_position,
   output logic                       index_event,
   output logic                       quad_error,
   output logic                       enc_line_fault,
   // Gated motion and origin search status.
   output logic                       drive_cw,
   output logic                       drive_ccw,
   output logic                       homing_busy,
   output logic                       home_done,
   output logic                       home_fail,
   // Commutation.
   output logic [sfl_pkg::STEP_W-1:0] commutation_step,
   output logic                       hall_invalid,
   output logic                       commutation_enable,
   // Power stage fault indication.
   output logic                       amp_fault_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers.

   // Turns a raw stop pin into an active flag under the selected polarity.
   function automatic logic lim_active(input logic raw, input logic act_high);
      lim_active = act_high ? raw : ~raw;
   endfunction

   // Maps positive-phase flags {A,B,C} onto a step; bit 3 marks a valid pattern.
   function automatic logic [3:0] hall_decode(input logic [2:0] ph);
      case (ph)
         3'b100:  hall_decode = 4'h8;
         3'b110:  hall_decode = 4'h9;
         3'b010:  hall_decode = 4'ha;
         3'b011:  hall_decode = 4'hb;
         3'b001:  hall_decode = 4'hc;
         3'b101:  hall_decode = 4'hd;
         default: hall_decode = 4'h0;
      endcase
   endfunction

   // Adds the phase setting to a step, modulo six.
   function automatic logic [2:0] step_shift(input logic [2:0] step, input logic [2:0] ofs);
      logic [3:0] sum;
      sum = {1'b0, step} + {1'b0, ofs};
      if (sum >= {1'b0, sfl_pkg::NUM_STEPS}) begin
         sum = sum - {1'b0, sfl_pkg::NUM_STEPS};
      end
      if (sum >= {1'b0, sfl_pkg::NUM_STEPS}) begin
         sum = sum - {1'b0, sfl_pkg::NUM_STEPS};
      end
      step_shift = sum[2:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation.

   logic [sfl_pkg::SYN_W-1:0] syn_in;
   logic [sfl_pkg::SYN_W-1:0] syn_q;

   // The encoder, stop, Hall and jumper pins are gathered into one vector so they share one synchroniser.
   assign syn_in[sfl_pkg::SYN_QA_P]   = quad_a_pos;
   assign syn_in[sfl_pkg::SYN_QA_N]   = quad_a_neg;
   assign syn_in[sfl_pkg::SYN_QB_P]   = quad_b_pos;
   assign syn_in[sfl_pkg::SYN_QB_N]   = quad_b_neg;
   assign syn_in[sfl_pkg::SYN_IX_P]   = index_pulse_pos;
   assign syn_in[sfl_pkg::SYN_IX_N]   = index_pulse_neg;
   assign syn_in[sfl_pkg::SYN_CW]     = cw_travel_stop;
   assign syn_in[sfl_pkg::SYN_CCW]    = ccw_travel_stop;
   assign syn_in[sfl_pkg::SYN_HOME]   = home_stop;
   assign syn_in[sfl_pkg::SYN_HALL_A] = hall_a;
   assign syn_in[sfl_pkg::SYN_HALL_B] = hall_b;
   assign syn_in[sfl_pkg::SYN_HALL_C] = hall_c;
   assign syn_in[sfl_pkg::SYN_JUMPER] = motor_type_jumper;

   // Three stages keep metastable pin levels away from every decision.
   sfl_sync #(
      .W    (sfl_pkg::SYN_W)
   ) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (syn_in), // R14
      .q    (syn_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Encoder receiver and quadrature counter.

   logic [2:0]               enc_ff;
   logic [2:0]               nxt_enc;
   logic [2:0]               prev_ff;
   logic [2:0]               nxt_prev;
   logic [sfl_pkg::POS_W-1:0] count_ff;
   logic [sfl_pkg::POS_W-1:0] nxt_count;
   logic [sfl_pkg::POS_W-1:0] index_pos_ff;
   logic [sfl_pkg::POS_W-1:0] nxt_index_pos;
   logic                     index_evt_ff;
   logic                     nxt_index_evt;
   logic                     qerr_ff;
   logic                     nxt_qerr;
   logic                     line_fault_ff;
   logic                     nxt_line_fault;
   logic                     a_chg;
   logic                     b_chg;
   logic                     step_up;

   assign a_chg   = enc_ff[0] ^ prev_ff[0];
   assign b_chg   = enc_ff[1] ^ prev_ff[1];
   assign step_up = enc_ff[0] ^ prev_ff[1];

   // A pair that shows equal levels is not a valid differential state, so the last value is held.
   always_comb begin
      nxt_enc        = enc_ff;
      nxt_line_fault = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (syn_q[2*i] != syn_q[2*i+1]) begin
            nxt_enc[i] = syn_q[2*i]; // R4
         end else begin
            nxt_line_fault = 1'b1;
         end
      end
      nxt_prev      = enc_ff;
      nxt_count     = count_ff;
      nxt_qerr      = 1'b0;
      nxt_index_evt = 1'b0;
      nxt_index_pos = index_pos_ff;
      // One channel change per cycle counts by one; both at once means an edge was missed.
      if (a_chg && b_chg) begin
         nxt_qerr = 1'b1;
      end else if (a_chg || b_chg) begin
         if (step_up) begin
            nxt_count = count_ff + 32'h0000_0001; // R13 R3 R2
         end else begin
            nxt_count = count_ff - 32'h0000_0001; // R13 R3 R2
         end
      end
      // The index rising edge marks a reference and latches the count.
      if (enc_ff[2] && !prev_ff[2]) begin
         nxt_index_evt = 1'b1; // R13
         nxt_index_pos = count_ff;
      end
   end

   // Encoder state registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enc_ff        <= sfl_pkg::ENC_RST;
         prev_ff       <= sfl_pkg::ENC_RST;
         count_ff      <= sfl_pkg::POS_RST;
         index_pos_ff  <= sfl_pkg::POS_RST;
         index_evt_ff  <= 1'b0;
         qerr_ff       <= 1'b0;
         line_fault_ff <= 1'b0;
      end else begin
         enc_ff        <= nxt_enc;
         prev_ff       <= nxt_prev;
         count_ff      <= nxt_count;
         index_pos_ff  <= nxt_index_pos;
         index_evt_ff  <= nxt_index_evt;
         qerr_ff       <= nxt_qerr;
         line_fault_ff <= nxt_line_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Travel stops and origin search.

   logic                cw_act;
   logic                ccw_act;
   logic                home_act;
   logic                home_cw;
   logic                home_ccw;
   logic                toward_hit;
   logic                away_hit;
   sfl_pkg::sfl_home_e  state_ff;
   sfl_pkg::sfl_home_e  nxt_state;
   logic                drive_cw_ff;
   logic                nxt_drive_cw;
   logic                drive_ccw_ff;
   logic                nxt_drive_ccw;
   logic                done_ff;
   logic                nxt_done;
   logic                fail_ff;
   logic                nxt_fail;

   // Stop flags under the chosen polarity.
   assign cw_act   = lim_active(syn_q[sfl_pkg::SYN_CW], limit_active_high);   // R7
   assign ccw_act  = lim_active(syn_q[sfl_pkg::SYN_CCW], limit_active_high);  // R7
   assign home_act = lim_active(syn_q[sfl_pkg::SYN_HOME], limit_active_high); // R7

   // Seeking moves toward the home stop; backing off and waiting for the mark move away.
   assign home_cw    = (state_ff == sfl_pkg::HOME_SEEK) ? !home_dir_ccw : home_dir_ccw;
   assign home_ccw   = !home_cw;
   assign toward_hit = home_dir_ccw ? ccw_act : cw_act;
   assign away_hit   = home_dir_ccw ? cw_act : ccw_act;

   // A travel stop met during the search aborts it rather than pushing into the stop.
   always_comb begin
      nxt_state = state_ff;
      nxt_done  = 1'b0;
      nxt_fail  = 1'b0;
      case (state_ff)
         sfl_pkg::HOME_IDLE: begin
            if (seek_origin_command) begin
               nxt_state = sfl_pkg::HOME_SEEK; // R6
            end
         end
         sfl_pkg::HOME_SEEK: begin
            if (home_act) begin
               nxt_state = sfl_pkg::HOME_BACKOFF; // R6
            end else if (toward_hit) begin
               nxt_state = sfl_pkg::HOME_IDLE;
               nxt_fail  = 1'b1;
            end
         end
         sfl_pkg::HOME_BACKOFF: begin
            if (!home_act) begin
               if (home_stop_on_index) begin
                  nxt_state = sfl_pkg::HOME_MARK; // R6
               end else begin
                  nxt_state = sfl_pkg::HOME_IDLE;
                  nxt_done  = 1'b1;
               end
            end else if (away_hit) begin
               nxt_state = sfl_pkg::HOME_IDLE;
               nxt_fail  = 1'b1;
            end
         end
         sfl_pkg::HOME_MARK: begin
            if (index_evt_ff) begin
               nxt_state = sfl_pkg::HOME_IDLE; // R6
               nxt_done  = 1'b1;
            end else if (away_hit) begin
               nxt_state = sfl_pkg::HOME_IDLE;
               nxt_fail  = 1'b1;
            end
         end
         default: begin
            nxt_state = sfl_pkg::HOME_IDLE;
         end
      endcase
      // The search owns the motor while it runs; stops gate every request.
      if (state_ff != sfl_pkg::HOME_IDLE) begin
         nxt_drive_cw  = home_cw && !cw_act;   // R5
         nxt_drive_ccw = home_ccw && !ccw_act; // R5
      end else begin
         nxt_drive_cw  = motion_request_cw && !cw_act;   // R5
         nxt_drive_ccw = motion_request_ccw && !ccw_act; // R5
      end
   end

   // Stop and search registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff     <= sfl_pkg::HOME_RST;
         drive_cw_ff  <= 1'b0;
         drive_ccw_ff <= 1'b0;
         done_ff      <= 1'b0;
         fail_ff      <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         drive_cw_ff  <= nxt_drive_cw;
         drive_ccw_ff <= nxt_drive_ccw;
         done_ff      <= nxt_done;
         fail_ff      <= nxt_fail;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hall commutation and power fault.

   logic                      brushless;
   logic [2:0]                phase_pos;
   logic [3:0]                hall_dec;
   logic [sfl_pkg::STEP_W-1:0] step_ff;
   logic [sfl_pkg::STEP_W-1:0] nxt_step;
   logic                      hinv_ff;
   logic                      nxt_hinv;
   logic                      comm_en_ff;
   logic                      nxt_comm_en;
   logic                      pf_any;
   logic                      amp_fault_ff;
   logic                      nxt_amp_fault;

   // Jumper high means position 1-2, a brushless motor.
   assign brushless = syn_q[sfl_pkg::SYN_JUMPER]; // R12
   // A low Hall level marks its phase positive in clockwise rotation.
   assign phase_pos = ~{syn_q[sfl_pkg::SYN_HALL_A], syn_q[sfl_pkg::SYN_HALL_B], syn_q[sfl_pkg::SYN_HALL_C]}; // R9
   assign hall_dec  = hall_decode(phase_pos); // R8
   assign pf_any    = |power_stage_faults;

   // Brush motors ignore the Hall pattern entirely.
   always_comb begin
      nxt_step      = sfl_pkg::STEP_RST;
      nxt_hinv      = 1'b0;
      nxt_comm_en   = brushless; // R11
      nxt_amp_fault = pf_any;    // R1
      if (brushless) begin
         if (hall_dec[3]) begin
            nxt_step = step_shift(hall_dec[2:0], hall_phase_setting); // R8 R10
         end else begin
            nxt_hinv = 1'b1;
         end
      end
   end

   // Commutation and fault registers.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         step_ff      <= sfl_pkg::STEP_RST;
         hinv_ff      <= 1'b0;
         comm_en_ff   <= 1'b0;
         amp_fault_ff <= 1'b0;
      end else begin
         step_ff      <= nxt_step;
         hinv_ff      <= nxt_hinv;
         comm_en_ff   <= nxt_comm_en;
         amp_fault_ff <= nxt_amp_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output drive.
   assign position_count     = count_ff;
   assign index_position     = index_pos_ff;
   assign index_event        = index_evt_ff;
   assign quad_error         = qerr_ff;
   assign enc_line_fault     = line_fault_ff;
   assign drive_cw           = drive_cw_ff;
   assign drive_ccw          = drive_ccw_ff;
   assign homing_busy        = (state_ff != sfl_pkg::HOME_IDLE);
   assign home_done          = done_ff;
   assign home_fail          = fail_ff;
   assign commutation_step   = step_ff;
   assign hall_invalid       = hinv_ff;
   assign commutation_enable = comm_en_ff;
   assign amp_fault_out      = amp_fault_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   chk_amp_fault_src: assert property (@(posedge clk) disable iff (!rstn) // R1
      1'b1 |=> (amp_fault_out == $past(pf_any)))
      else $error("fault output not tied to power stage faults");

   chk_edge_resolve: assert property (@(posedge clk) disable iff (!rstn) // R3
      (syn_q[0] != syn_q[1]) && (syn_q[0] != enc_ff[0]) |=> a_chg)
      else $error("quadrature edge not resolved");

   chk_diff_hold: assert property (@(posedge clk) disable iff (!rstn) // R4
      (syn_q[2] == syn_q[3]) |=> $stable(enc_ff[1]))
      else $error("equal differential pair changed channel b");

   chk_cw_block: assert property (@(posedge clk) disable iff (!rstn) // R5
      cw_act |=> !drive_cw)
      else $error("clockwise motion while clockwise stop active");

   chk_ccw_block: assert property (@(posedge clk) disable iff (!rstn) // R5
      ccw_act |=> !drive_ccw)
      else $error("counter-clockwise motion while its stop active");

   chk_limit_polarity: assert property (@(posedge clk) disable iff (!rstn) // R7
      (syn_q[sfl_pkg::SYN_CW] == limit_active_high) |=> !drive_cw)
      else $error("stop polarity not honoured");

   chk_home_reverse: assert property (@(posedge clk) disable iff (!rstn) // R6
      (state_ff == sfl_pkg::HOME_SEEK) && home_act |=> (state_ff == sfl_pkg::HOME_BACKOFF) ##1 (home_cw == $past(home_dir_ccw, 2)))
      else $error("origin search did not reverse on the home stop");

   chk_home_mark: assert property (@(posedge clk) disable iff (!rstn) // R6
      (state_ff == sfl_pkg::HOME_MARK) && index_evt_ff |=> (state_ff == sfl_pkg::HOME_IDLE) && home_done)
      else $error("origin search did not stop at the index");

   chk_count_step: assert property (@(posedge clk) disable iff (!rstn) // R13
      (a_chg ^ b_chg) && step_up |=> (position_count == $past(count_ff) + 32'h0000_0001))
      else $error("count did not advance by one");

   chk_hall_step: assert property (@(posedge clk) disable iff (!rstn) // R8
      brushless && hall_dec[3] |=> (commutation_step < sfl_pkg::NUM_STEPS) && !hall_invalid)
      else $error("valid hall pattern gave no step");

   chk_hall_default: assert property (@(posedge clk) disable iff (!rstn) // R10
      brushless && (hall_phase_setting == 3'h0) && hall_dec[3] |=> (commutation_step == $past(hall_dec[2:0])))
      else $error("zero phase setting shifted the step");

   chk_brush_ignore: assert property (@(posedge clk) disable iff (!rstn) // R11
      !brushless |=> (commutation_step == sfl_pkg::STEP_RST) && !hall_invalid && !commutation_enable)
      else $error("brush motor used hall inputs");

endmodule

/* hw/sfl_pkg.sv */
// Shared constants and types of the servo feedback, limit and homing block.
package sfl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing of the encoder path at the 40 MHz system clock.
   localparam int CLK_PERIOD_NS    = 25;
   localparam int CLK_FREQ_HZ      = 40_000_000;
   localparam int ENC_MAX_RATE_HZ  = 2_500_000;
   localparam int EDGE_SEP_NS      = 100;
   // Shortest period of one encoder signal, rounded down to whole cycles.
   localparam int ENC_MIN_PER_CYC  = CLK_FREQ_HZ / ENC_MAX_RATE_HZ;
   // Shortest spacing of two quadrature edges, rounded up to whole cycles.
   localparam int EDGE_SEP_CYC     = (EDGE_SEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and values after reset.
   localparam int          POS_W       = 32;
   localparam int          PFAULT_W    = 3;
   localparam int          HALL_W      = 3;
   localparam int          STEP_W      = 3;
   localparam logic [31:0] POS_RST     = 32'h0000_0000;
   localparam logic [2:0]  STEP_RST    = 3'h0;
   localparam logic [2:0]  NUM_STEPS   = 3'h6;
   localparam logic [2:0]  ENC_RST     = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions inside the synchronised input vector.
   localparam int SYN_QA_P   = 0;
   localparam int SYN_QA_N   = 1;
   localparam int SYN_QB_P   = 2;
   localparam int SYN_QB_N   = 3;
   localparam int SYN_IX_P   = 4;
   localparam int SYN_IX_N   = 5;
   localparam int SYN_CW     = 6;
   localparam int SYN_CCW    = 7;
   localparam int SYN_HOME   = 8;
   localparam int SYN_HALL_A = 9;
   localparam int SYN_HALL_B = 10;
   localparam int SYN_HALL_C = 11;
   localparam int SYN_JUMPER = 12;
   localparam int SYN_W      = 13;
   localparam logic [12:0] SYN_RST = 13'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // States of the origin search.
   typedef enum logic [2:0] {
      HOME_IDLE    = 3'b000,
      HOME_SEEK    = 3'b001,
      HOME_BACKOFF = 3'b010,
      HOME_MARK    = 3'b011
   } sfl_home_e;

   localparam sfl_home_e HOME_RST = HOME_IDLE;

endpackage

/* hw/sfl_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module sfl_sync #(
   parameter int W = 13
) (
   // Clock and reset.
   input  logic         clk,
   input  logic         rstn,
   // Asynchronous inputs and their filtered image.
   input  logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_q;

   ////////////////////////////////////////////////////////////////////////////
   // Each bit follows stage three only when stages two and three agree.
   always_comb begin
      nxt_q = q_ff;
      for (int i = 0; i < W; i++) begin
         if (s2_ff[i] == s3_ff[i]) begin
            nxt_q[i] = s3_ff[i]; // R14
         end
      end
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff  <= '0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= nxt_q;
      end
   end

   assign q = q_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Agreeing late stages must reach the output one cycle later.
   chk_sync_agree: assert property (@(posedge clk) disable iff (!rstn) // R14
      (s2_ff == s3_ff) |=> (q_ff == $past(s3_ff)))
      else $error("synchroniser output missed an agreed value");

endmodule

/* dv/sfl_enc_model.sv */
// Behavioural encoder that drives both quadrature pairs and the index pair.
`timescale 1ns/1ps
module sfl_enc_model (
   // Clock and step requests.
   input  logic clk,
   input  logic step,
   input  logic dir,
   input  logic mark,
   // Differential encoder pins.
   output logic qap,
   output logic qan,
   output logic qbp,
   output logic qbn,
   output logic ixp,
   output logic ixn
);
   logic [1:0] ph = 2'h0;
   // Moves one quadrature state per step, A leading B when dir is high.
   always @(posedge clk) begin
      if (step) ph <= dir ? ph + 2'h1 : ph - 2'h1;
   end
   // Each channel is sent with its complement.
   assign qap = ph[1] ^ ph[0];
   assign qan = ~qap;
   assign qbp = ph[1];
   assign qbn = ~qbp;
   assign ixp = mark;
   assign ixn = ~mark;
endmodule

/* dv/tb.sv */
// Self-checking bench of the feedback, stop, origin, Hall and fault logic.
`timescale 1ns/1ps
module tb;
   logic clk = 0, rstn = 0, step = 0, dir = 0, mark = 0, qap, qan, qbp, qbn, ixp, ixn;
   logic cws = 0, ccws = 0, homs = 0, lah = 0, ha = 0, hb = 0, hc = 0, mtj = 1;
   logic rcw = 0, rccw = 0, seek = 0, hix = 0, ixe, drcw, drccw, busy, done, cen, afo, hinv;
   logic [2:0]  hps = 3'h0, psf = 3'h0, cstep;
   logic [31:0] pos, ixpos;
   logic [2:0]  pat [6] = '{3'h3, 3'h1, 3'h5, 3'h4, 3'h6, 3'h2};
   integer      seed = 32'hb31b812c, fail_count = 0, num_checks = 0, i, n, expc = 0;
   // Clock at 40 MHz.
   always #12.5 clk = ~clk;
   sfl_enc_model u_sfl_enc_model (.clk(clk), .step(step), .dir(dir), .mark(mark), .qap(qap), .qan(qan),
      .qbp(qbp), .qbn(qbn), .ixp(ixp), .ixn(ixn));
   sfl_feedback u_sfl_feedback (.clk(clk), .rstn(rstn), .quad_a_pos(qap), .quad_a_neg(qan), .quad_b_pos(qbp),
      .quad_b_neg(qbn), .index_pulse_pos(ixp), .index_pulse_neg(ixn), .cw_travel_stop(cws),
      .ccw_travel_stop(ccws), .home_stop(homs), .limit_active_high(lah), .hall_a(ha), .hall_b(hb),
      .hall_c(hc), .hall_phase_setting(hps), .motor_type_jumper(mtj), .motion_request_cw(rcw),
      .motion_request_ccw(rccw), .seek_origin_command(seek), .home_dir_ccw(1'b0), .home_stop_on_index(hix),
      .power_stage_faults(psf), .position_count(pos), .index_position(ixpos), .index_event(ixe),
      .quad_error(), .enc_line_fault(), .drive_cw(drcw), .drive_ccw(drccw), .homing_busy(busy),
      .home_done(done), .home_fail(), .commutation_step(cstep), .hall_invalid(hinv), .commutation_enable(cen),
      .amp_fault_out(afo));
   ////////////////////////////////////////////////////////////////////////////
   // Compares one value and counts the result.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits a number of falling edges.
   task wt(input integer c);
      repeat (c) @(negedge clk);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task give_verdict;
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #50000;
      fail_count++;
      give_verdict;
   end
   // Main sequence of scenarios.
   initial begin
      wt(6);
      rstn = 1;
      lah = $random(seed);
      {cws, ccws, homs} = {3{~lah}};
      wt(8);
      for (i = 0; i < 40; i++) begin
         dir = (i < 6) | $random(seed);
         expc += dir ? 1 : -1;
         step = 1;
         wt(1);
         step = 0;
         wt(3);
      end
      wt(8);
      chk(pos, expc);
      mark = 1;
      n = 0;
      repeat (10) begin @(negedge clk); n |= ixe; end
      mark = 0;
      chk(n, 1);
      chk(ixpos, expc);
      $display("Encoder test done");
      {rcw, rccw, cws} = {2'h3, lah};
      wt(8);
      chk({drcw, drccw}, 2'h1);
      {cws, ccws} = {~lah, lah};
      wt(8);
      chk({drcw, drccw}, 2'h2);
      {rcw, rccw, ccws} = {2'h0, ~lah};
      for (i = 0; i < 6; i++) begin
         n = {$random(seed)} % 6;
         {ha, hb, hc, hps} = {pat[i], n[2:0]};
         wt(8);
         chk(cstep, (i + n) % 6);
      end
      {ha, hb, hc} = 3'h7;
      wt(8);
      chk({hinv, cstep}, 4'h8);
      mtj = 0;
      wt(8);
      chk({cen, cstep}, 0);
      for (i = 0; i < 4; i++) begin
         psf = $random(seed);
         wt(2);
         chk(afo, |psf);
      end
      psf = 0;
      seek = 1;
      wt(1);
      seek = 0;
      wt(3);
      chk({busy, drcw}, 2'h3);
      homs = lah;
      wt(8);
      chk(drccw, 1);
      homs = ~lah;
      n = 0;
      repeat (12) begin @(negedge clk); n |= done; end
      chk(n, 1);
      hix = 1;
      seek = 1;
      wt(1);
      seek = 0;
      homs = lah;
      wt(8);
      homs = ~lah;
      wt(8);
      chk(busy, 1);
      mark = 1;
      n = 0;
      repeat (12) begin @(negedge clk); n |= done; end
      mark = 0;
      chk({n[0], busy}, 2'h2);
      $display("Stop, Hall, fault and origin tests done");
      give_verdict;
   end
endmodule
